// >>> design/mbg_consts.vh
// timing constants for the plate bracket gate sequencer
// assumes a 100 MHz system clock; times in ns, counts derived from the period
`ifndef MBG_CONSTS_VH
`define MBG_CONSTS_VH
`define MBG_CLK_PERIOD_NS 10
`define MBG_PLATE_LEAD_NS 35
`define MBG_PLATE_TAIL_NS 1000
`define MBG_MIN_DELAY_BRK_NS 35
`define MBG_MIN_DELAY_PLAIN_NS 25
`define MBG_BRK_EXTRA_NS 10
`define MBG_REF_DELAY_NS 12
`define MBG_PERIOD_BRK_NS 160000
`define MBG_PERIOD_PLAIN_NS 1000
// least times round up, longest round down
`define MBG_PLATE_LEAD_CYC ((`MBG_PLATE_LEAD_NS + `MBG_CLK_PERIOD_NS - 1) / `MBG_CLK_PERIOD_NS)
`define MBG_PLATE_TAIL_CYC (`MBG_PLATE_TAIL_NS / `MBG_CLK_PERIOD_NS)
`define MBG_MIN_DELAY_BRK_CYC ((`MBG_MIN_DELAY_BRK_NS + `MBG_CLK_PERIOD_NS - 1) / `MBG_CLK_PERIOD_NS)
`define MBG_MIN_DELAY_PLAIN_CYC ((`MBG_MIN_DELAY_PLAIN_NS + `MBG_CLK_PERIOD_NS - 1) / `MBG_CLK_PERIOD_NS)
`define MBG_BRK_EXTRA_CYC ((`MBG_BRK_EXTRA_NS + `MBG_CLK_PERIOD_NS - 1) / `MBG_CLK_PERIOD_NS)
`define MBG_REF_DELAY_CYC (`MBG_REF_DELAY_NS / `MBG_CLK_PERIOD_NS)
`define MBG_PERIOD_BRK_CYC ((`MBG_PERIOD_BRK_NS + `MBG_CLK_PERIOD_NS - 1) / `MBG_CLK_PERIOD_NS)
`define MBG_PERIOD_PLAIN_CYC ((`MBG_PERIOD_PLAIN_NS + `MBG_CLK_PERIOD_NS - 1) / `MBG_CLK_PERIOD_NS)
`define MBG_CNT_W 16
`endif

// >>> design/mbg_sync.v
// two-stage synchroniser for one level from outside the clock domain
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
module mbg_sync
(
    input wire clk,      // system clock
    input wire sys_rst,  // sync reset, high
    input wire d_in,     // async level
    output reg d_out     // synchronised level
);
    reg meta_r;

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_r <= 1'b0;
            d_out <= 1'b0;
        end
        else
        begin
            meta_r <= d_in;
            d_out <= meta_r;
        end
    end
endmodule

// >>> design/mbg_gate_seq.v
// gate sequencer: trigger edge to photocathode gate, plate bracket and timing reference
// assumes trigger, bracket setting and generation strap come from pins (synchronised here)
// Summary of operation
// - bracketing: plate off except around each gate
// - plate turns on 40 ns (4 cycles, 35 ns rounded up) before gate
// - plate stays on 1 us after gate
// - bracket trigger-to-gate delay never below 35 ns
// - bracketing adds 10 ns to gate path
// - repetition capped 6.25 kHz bracketed, 1 MHz otherwise
// - timing reference follows trigger after about 12 ns
// - bracket placed automatically, no user timing
// - third generation tube: bracket setting ignored
`timescale 1ns/1ps
`include "mbg_consts.vh"
module mbg_gate_seq
#(
    parameter CNT_W = `MBG_CNT_W,
    parameter PERIOD_BRK_CYC = `MBG_PERIOD_BRK_CYC
)
(
    input wire clk,                          // 100 MHz clock
    input wire sys_rst,                      // sync reset, high
    input wire trig_in,                      // external trigger pin, rising edge
    input wire bracket_on,                   // host bracket setting, level
    input wire gen3_fitted,                  // strap: third generation tube fitted
    input wire [CNT_W-1:0] gate_delay,       // requested trigger-to-gate delay, cycles
    input wire [CNT_W-1:0] gate_width,       // gate width, cycles (0 treated as 1)
    output reg photocathode_gate,            // photocathode gate on
    output reg plate_bias_on,                // plate bias on
    output reg timing_reference_output,      // timing reference pulse
    output reg bracket_active,               // bracket mode in force
    output reg trig_dropped                  // pulse: trigger ignored while busy
);
    // ========================================
    // state and constants
    localparam ST_IDLE = 2'h0;
    localparam ST_DELAY = 2'h1;
    localparam ST_GATE = 2'h2;
    localparam ST_TAIL = 2'h3;
    // counts are worked out as integers, then cut to the counter width on purpose
    localparam integer LEAD_INT = `MBG_PLATE_LEAD_CYC;
    localparam integer TAIL_INT = `MBG_PLATE_TAIL_CYC;
    localparam integer MIN_BRK_INT = `MBG_MIN_DELAY_BRK_CYC;
    localparam integer MIN_PLAIN_INT = `MBG_MIN_DELAY_PLAIN_CYC;
    localparam integer EXTRA_INT = `MBG_BRK_EXTRA_CYC;
    localparam integer REF_INT = `MBG_REF_DELAY_CYC;
    localparam integer PER_PLAIN_INT = `MBG_PERIOD_PLAIN_CYC;
    localparam integer PER_BRK_INT = PERIOD_BRK_CYC;
    localparam [CNT_W-1:0] LEAD_CYC = LEAD_INT[CNT_W-1:0];
    localparam [CNT_W-1:0] TAIL_CYC = TAIL_INT[CNT_W-1:0];
    localparam [CNT_W-1:0] MIN_BRK_CYC = MIN_BRK_INT[CNT_W-1:0];
    localparam [CNT_W-1:0] MIN_PLAIN_CYC = MIN_PLAIN_INT[CNT_W-1:0];
    localparam [CNT_W-1:0] EXTRA_CYC = EXTRA_INT[CNT_W-1:0];
    // reference count must stay at least 1, the load below subtracts one
    localparam [CNT_W-1:0] REF_CYC = REF_INT[CNT_W-1:0];
    localparam [CNT_W-1:0] PER_PLAIN_CYC = PER_PLAIN_INT[CNT_W-1:0];
    localparam [CNT_W-1:0] PER_BRK_CYC = PER_BRK_INT[CNT_W-1:0];

    // ========================================
    // pin synchronisers
    wire trig_s;
    wire brk_s;
    wire gen3_s;

    mbg_sync u_sync_trig (.clk(clk), .sys_rst(sys_rst), .d_in(trig_in), .d_out(trig_s));
    mbg_sync u_sync_brk (.clk(clk), .sys_rst(sys_rst), .d_in(bracket_on), .d_out(brk_s));
    mbg_sync u_sync_gen3 (.clk(clk), .sys_rst(sys_rst), .d_in(gen3_fitted), .d_out(gen3_s));

    reg trig_d_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [CNT_W-1:0] cnt_r;
    reg [CNT_W-1:0] cnt_nxt;
    reg [CNT_W-1:0] per_r;
    reg [CNT_W-1:0] per_nxt;
    reg [CNT_W-1:0] ref_r;
    reg [CNT_W-1:0] ref_nxt;
    reg mode_r;
    reg mode_nxt;
    reg ref_run_r;
    reg ref_run_nxt;

    wire trig_edge = trig_s & ~trig_d_r;
    // bracket mode only when asked and the tube is not third generation
    wire brk_req = brk_s & ~gen3_s;
    wire busy = (state_r != ST_IDLE) || (per_r != {CNT_W{1'b0}});
    wire [CNT_W-1:0] width_eff = (gate_width == {CNT_W{1'b0}}) ? {{(CNT_W-1){1'b0}}, 1'b1}
                                                               : gate_width;

    // ========================================
    // delay clamp
    // bracket path adds a fixed insertion, then the floor is the bracket minimum delay
    reg [CNT_W-1:0] dly_plain;
    reg [CNT_W-1:0] dly_eff;
    always @*
    begin
        dly_plain = (gate_delay < MIN_PLAIN_CYC) ? MIN_PLAIN_CYC : gate_delay;
        if (brk_req)
        begin
            dly_eff = dly_plain + EXTRA_CYC;
            if (dly_eff < MIN_BRK_CYC)
                dly_eff = MIN_BRK_CYC;
        end
        else
            dly_eff = dly_plain;
    end

    // ========================================
    // sequencer
    always @*
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        per_nxt = (per_r != {CNT_W{1'b0}}) ? per_r - {{(CNT_W-1){1'b0}}, 1'b1} : per_r;
        mode_nxt = mode_r;
        ref_nxt = ref_r;
        ref_run_nxt = ref_run_r;
        if (ref_run_r)
        begin
            if (ref_r == {CNT_W{1'b0}})
                ref_run_nxt = 1'b0;
            else
                ref_nxt = ref_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
        if (state_r == ST_IDLE && !busy)
            mode_nxt = brk_req;
        case (state_r)
            ST_IDLE:
            begin
                if (trig_edge && !busy)
                begin
                    // repetition limit counted from the accepted trigger
                    per_nxt = (brk_req ? PER_BRK_CYC : PER_PLAIN_CYC)
                              - {{(CNT_W-1){1'b0}}, 1'b1};
                    mode_nxt = brk_req;
                    cnt_nxt = dly_eff - {{(CNT_W-1){1'b0}}, 1'b1};
                    state_nxt = ST_DELAY;
                    ref_nxt = REF_CYC - {{(CNT_W-1){1'b0}}, 1'b1};
                    ref_run_nxt = 1'b1;
                end
            end
            ST_DELAY:
            begin
                if (cnt_r == {CNT_W{1'b0}})
                begin
                    cnt_nxt = width_eff - {{(CNT_W-1){1'b0}}, 1'b1};
                    state_nxt = ST_GATE;
                end
                else
                    cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
            end
            ST_GATE:
            begin
                if (cnt_r == {CNT_W{1'b0}})
                begin
                    cnt_nxt = TAIL_CYC - {{(CNT_W-1){1'b0}}, 1'b1};
                    state_nxt = mode_r ? ST_TAIL : ST_IDLE;
                end
                else
                    cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
            end
            ST_TAIL:
            begin
                if (cnt_r == {CNT_W{1'b0}})
                    state_nxt = ST_IDLE;
                else
                    cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // plate window derived from the sequencer alone, no user timing
    reg plate_nxt;
    always @*
    begin
        if (!mode_nxt)
            plate_nxt = 1'b1;
        else
            case (state_nxt)
                ST_DELAY: plate_nxt = (cnt_nxt < LEAD_CYC);
                ST_GATE: plate_nxt = 1'b1;
                ST_TAIL: plate_nxt = 1'b1;
                default: plate_nxt = 1'b0;
            endcase
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            trig_d_r <= 1'b0;
            state_r <= ST_IDLE;
            cnt_r <= {CNT_W{1'b0}};
            per_r <= {CNT_W{1'b0}};
            ref_r <= {CNT_W{1'b0}};
            ref_run_r <= 1'b0;
            mode_r <= 1'b0;
            photocathode_gate <= 1'b0;
            plate_bias_on <= 1'b1;
            timing_reference_output <= 1'b0;
            bracket_active <= 1'b0;
            trig_dropped <= 1'b0;
        end
        else
        begin
            trig_d_r <= trig_s;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            per_r <= per_nxt;
            ref_r <= ref_nxt;
            ref_run_r <= ref_run_nxt;
            mode_r <= mode_nxt;
            photocathode_gate <= (state_nxt == ST_GATE);
            plate_bias_on <= plate_nxt;
            // one-cycle reference pulse at the end of the reference delay
            timing_reference_output <= ref_run_r && (ref_r == {CNT_W{1'b0}});
            bracket_active <= mode_nxt;
            trig_dropped <= trig_edge && busy;
        end
    end
endmodule

// >>> tb/mbg_trig_src.sv
// trigger source model: one asynchronous pulse per request
// assumes fire is a one-cycle request from the bench
`timescale 1ns/1ps
// ==================== trigger source
module mbg_trig_src
(
    input wire fire,    // request a pulse
    output reg trig_in  // trigger pin
);
    initial trig_in = 1'b0;
    // off-edge start keeps the synchroniser honest
    always @(posedge fire)
    begin
        #3 trig_in = 1'b1;
        #40 trig_in = 1'b0;
    end
endmodule

// >>> tb/mbg_gate_checker.sv
// port checker for the gate sequencer
// assumes bound into mbg_gate_seq, one clock domain
`timescale 1ns/1ps
// ==================== checker
module mbg_chk
#(
    parameter CNT_W = 16,
    parameter PERIOD_BRK_CYC = 16000
)
(
    input wire clk,                     // clock
    input wire sys_rst,                 // reset
    input wire trig_in,                 // trigger
    input wire bracket_on,              // bracket setting
    input wire gen3_fitted,             // strap
    input wire [CNT_W-1:0] gate_delay,  // delay
    input wire [CNT_W-1:0] gate_width,  // width
    input wire photocathode_gate,       // gate
    input wire plate_bias_on,           // plate
    input wire timing_reference_output, // reference
    input wire bracket_active,          // mode
    input wire trig_dropped             // drop pulse
);
    reg [17:0] gap_r;
    // saturates so a long idle never wraps into a false short gap
    always @(posedge clk)
        if (sys_rst)
            gap_r <= 18'h3FFFF;
        else if (timing_reference_output)
            gap_r <= 18'h00000;
        else if (gap_r != 18'h3FFFF)
            gap_r <= gap_r + 18'h00001;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_tail;
        (plate_bias_on throughout ##99 1'b1) ##1 !plate_bias_on;
    endsequence
    sequence s_quiet3;
        !photocathode_gate[*3];
    endsequence
    chk_gate_in_plate: assert property (photocathode_gate |-> plate_bias_on)
        else $error("gate outside plate interval");
    chk_plate_lead: assert property ($rose(photocathode_gate) && bracket_active
        |-> $past(plate_bias_on, 4) && !$past(plate_bias_on, 5)) else $error("plate lead");
    chk_plate_tail: assert property ($fell(photocathode_gate) && bracket_active
        |-> s_tail) else $error("plate tail");
    chk_brk_min_delay: assert property ($rose(timing_reference_output) && bracket_active
        |-> s_quiet3) else $error("bracket gate too early");
    chk_rep_spacing: assert property ($rose(timing_reference_output)
        |-> gap_r >= (bracket_active ? PERIOD_BRK_CYC - 1 : 99)) else $error("repeat too fast");
    chk_ref_follows: assert property ($rose(trig_in)
        |-> ##[3:6] (timing_reference_output || trig_dropped)) else $error("no reference");
    chk_ref_pulse: assert property (timing_reference_output |=> !timing_reference_output)
        else $error("reference too long");
    chk_plain_plate: assert property (!bracket_active ##1 !bracket_active |-> plate_bias_on)
        else $error("plate off in plain mode");
    chk_gen3_block: assert property ($rose(bracket_active)
        |-> $past(bracket_on, 3) && !$past(gen3_fitted, 3)) else $error("bracket not allowed");
    chk_drop_pulse: assert property (trig_dropped |=> !trig_dropped)
        else $error("drop pulse too long");
endmodule
bind mbg_gate_seq mbg_chk #(.CNT_W(CNT_W), .PERIOD_BRK_CYC(PERIOD_BRK_CYC)) chk (.clk(clk),
    .sys_rst(sys_rst), .trig_in(trig_in), .bracket_on(bracket_on), .gen3_fitted(gen3_fitted),
    .gate_delay(gate_delay), .gate_width(gate_width), .photocathode_gate(photocathode_gate),
    .plate_bias_on(plate_bias_on), .timing_reference_output(timing_reference_output),
    .bracket_active(bracket_active), .trig_dropped(trig_dropped));

// >>> tb/tb_top.sv
// bench: plain runs and repeat spacing, bracket runs and repeat spacing, then a strapped run
// assumes mbg_gate_seq and mbg_trig_src; short bracket period in sim
`timescale 1ns/1ps
// ==================== bench
module tb_top;
    reg clk, sys_rst, fire, bracket_on, gen3_fitted;
    reg [15:0] gate_delay, gate_width;
    wire trig_in, gate, plate, ref_o, brk_act, dropped;
    integer fail_count = 0, check_count = 0, n, p;
    mbg_trig_src src (.fire(fire), .trig_in(trig_in));
    mbg_gate_seq #(.PERIOD_BRK_CYC(200)) dut (.clk(clk), .sys_rst(sys_rst), .trig_in(trig_in),
        .bracket_on(bracket_on), .gen3_fitted(gen3_fitted), .gate_delay(gate_delay),
        .gate_width(gate_width), .photocathode_gate(gate), .plate_bias_on(plate),
        .timing_reference_output(ref_o), .bracket_active(brk_act), .trig_dropped(dropped));
    task give_verdict;
    begin
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    task cmp(input string nm, input [15:0] e, input [15:0] g);
    begin
        check_count = check_count + 1;
        if (g !== e)
        begin
            fail_count = fail_count + 1;
            $display("[ERR] %0s expected %0d seen %0d", nm, e, g);
        end
    end
    endtask
    task lim(input integer m);
    begin
        if (n >= m)
        begin
            fail_count = fail_count + 1;
            give_verdict;
        end
    end
    endtask
    task pulse;
    begin
        @(negedge clk) fire = 1'b1;
        @(negedge clk) fire = 1'b0;
        n = 0;
    end
    endtask
    task run(input [15:0] dl, input [15:0] wd, input brk, input [15:0] lat, input [15:0] ld,
        input [15:0] w, input [15:0] tl);
    begin
        @(negedge clk) gate_delay = dl;
        gate_width = wd;
        repeat (20) @(negedge clk);
        cmp("mode", brk, brk_act);
        cmp("idle_plate", !brk, plate);
        pulse;
        while (ref_o !== 1'b1 && n < 20)
            @(negedge clk) n = n + 1;
        lim(20);
        cmp("ref_delay", 16'h0003, n);
        n = 0;
        p = 0;
        while (gate !== 1'b1 && n < 300)
        begin
            p = p + plate;
            @(negedge clk) n = n + 1;
        end
        lim(300);
        cmp("latency", lat, n);
        cmp("lead", ld, p);
        n = 0;
        while (gate === 1'b1 && n < 300)
            @(negedge clk) n = n + 1;
        lim(300);
        cmp("width", w, n);
        n = 0;
        while (plate === 1'b1 && n < 150)
            @(negedge clk) n = n + 1;
        cmp("tail", tl, n);
        repeat (300) @(negedge clk);
    end
    endtask
    // second edge lands inside or after the repeat hold-off
    task gap_test(input [15:0] g, input drop);
    begin
        pulse;
        repeat (g) @(negedge clk);
        pulse;
        p = 0;
        while (ref_o !== 1'b1 && n < 12)
        begin
            p = p | dropped;
            @(negedge clk) n = n + 1;
        end
        cmp("dropped", drop, p);
        cmp("ref_seen", !drop, ref_o);
        repeat (300) @(negedge clk);
    end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        sys_rst = 1'b1;
        fire = 1'b0;
        bracket_on = 1'b0;
        gen3_fitted = 1'b0;
        gate_delay = 16'h0003;
        gate_width = 16'h0001;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        run(16'h0000, 16'h0000, 1'b0, 16'h0002, 16'h0002, 16'h0001, 16'h0096);
        run(16'h0005, 16'h0003, 1'b0, 16'h0004, 16'h0004, 16'h0003, 16'h0096);
        gap_test(16'h0028, 1'b1);
        gap_test(16'h006E, 1'b0);
        bracket_on = 1'b1;
        run(16'h0003, 16'h0002, 1'b1, 16'h0003, 16'h0003, 16'h0002, 16'h0064);
        run(16'h0000, 16'h0001, 1'b1, 16'h0003, 16'h0003, 16'h0001, 16'h0064);
        run(16'h000A, 16'h0005, 1'b1, 16'h000A, 16'h0004, 16'h0005, 16'h0064);
        gap_test(16'h0096, 1'b1);
        gap_test(16'h00D2, 1'b0);
        gen3_fitted = 1'b1;
        run(16'h0003, 16'h0002, 1'b0, 16'h0002, 16'h0002, 16'h0002, 16'h0096);
        give_verdict;
    end
endmodule
